// [rtl/fpt_cfg.svh]
// Constants for the flash protection and timing block
`ifndef FPT_CFG_SVH
`define FPT_CFG_SVH

// ****************************************
// Memory map
// ****************************************
`define FPT_SRAM_BASE 32'h2000_0000
`define FPT_BB_ALIAS_BASE 32'h2200_0000
`define FPT_BB_ALIAS_END 32'h2400_0000
`define FPT_BB_BYTE_LSB 5
`define FPT_BB_BIT_LSB 2

// ****************************************
// Flash geometry
// ****************************************
`define FPT_UNIT_LSB 10
`define FPT_REGION_LSB 11

// ****************************************
// Commit and keys
// ****************************************
`define FPT_KEY 16'hA442
`define FPT_CMD_WRITE 4'h1
`define FPT_CMD_ERASE 4'h2
`define FPT_CMD_COMMIT 4'h8
`define FPT_COMMIT_RE0 32'h0000_0000
`define FPT_COMMIT_PE0 32'h0000_0001

// ****************************************
// Reset values and timing
// ****************************************
`define FPT_USEC_RESET 8'h31
`define FPT_PROT_RESET 32'hFFFF_FFFF
`define FPT_PROG_US 20
`define FPT_ERASE_US 100

`endif

// [rtl/fpt_pkg.sv]
// Types for the flash protection and timing block
package fpt_pkg;

    typedef enum logic [1:0]
    {
        FPT_IDLE,
        FPT_BUSY
    } fpt_state_t;

    typedef enum logic [1:0]
    {
        FPT_OP_PROG,
        FPT_OP_ERASE,
        FPT_OP_COMMIT
    } fpt_op_t;

endpackage

// [rtl/fpt_usec_timer.sv]
// Microsecond tick generator and operation length counter
`timescale 1ns/100ps
`include "fpt_cfg.svh"

module fpt_usec_timer #(
    parameter int RW = 8,
    parameter int CW = 8
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Control
    input wire logic [RW-1:0] reload,
    input wire logic start,
    input wire logic [CW-1:0] length_us,
    // Status
    output logic done
);

    logic [RW-1:0] tick_count;
    logic [CW-1:0] us_left;
    logic running;
    wire tick = running && (tick_count == '0);
    wire last = tick && (us_left == CW'(1));

    // ****************************************
    // Counters
    // ****************************************
    // Reload paces microseconds
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            tick_count <= '0;
            us_left <= '0;
            running <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= last;
            if (start)
            begin
                running <= 1'b1;
                tick_count <= reload;
                us_left <= length_us;
            end
            else if (running)
            begin
                tick_count <= tick ? reload : tick_count - RW'(1);
                if (tick)
                    us_left <= us_left - CW'(1);
                if (last)
                    running <= 1'b0;
            end
        end
    end

endmodule

// [rtl/fpt_bitband.sv]
// Bit-band alias address decoder
`timescale 1ns/100ps
`include "fpt_cfg.svh"

module fpt_bitband (
    // Address in
    input wire logic [31:0] addr,
    // Decoded
    output logic hit,
    output logic [31:0] byte_addr,
    output logic [2:0] bit_num
);

    wire [31:0] offs = addr - `FPT_BB_ALIAS_BASE;
    assign hit = (addr >= `FPT_BB_ALIAS_BASE) && (addr < `FPT_BB_ALIAS_END);
    assign byte_addr = `FPT_SRAM_BASE + {5'h0_0, offs[31:`FPT_BB_BYTE_LSB]};
    assign bit_num = offs[`FPT_BB_BIT_LSB+2:`FPT_BB_BIT_LSB];

endmodule

// [rtl/fpt_core.sv]
// Flash protection, operation timing and bit-band access logic
`timescale 1ns/100ps
`include "fpt_cfg.svh"

module fpt_core #(
    parameter int NREG = 32,
    parameter int AW = 16,
    parameter int DEPTH = 16384
)
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // Protection register writes
    input wire logic PROT_WR,
    input wire logic PROT_SEL_PE,
    input wire logic [NREG-1:0] PROT_WDATA,
    output logic [NREG-1:0] REGION_PROGRAM_ENABLE,
    output logic [NREG-1:0] REGION_READ_ENABLE,
    output logic [NREG-1:0] COMMITTED_PE,
    output logic [NREG-1:0] COMMITTED_RE,
    // Microsecond reload
    input wire logic USEC_WR,
    input wire logic [7:0] USEC_WDATA,
    output logic [7:0] MICROSECOND_RELOAD,
    // Flash command
    input wire logic CTRL_WR,
    input wire logic [31:0] CTRL_WDATA,
    input wire logic [31:0] FLASH_ADDRESS_REG,
    input wire logic [31:0] FLASH_DATA,
    output logic BUSY,
    // Fault status
    input wire logic ACCESS_FAULT_MASK,
    input wire logic FAULT_CLEAR,
    output logic ACCESS_FAULT_RAW,
    output logic ACCESS_FAULT_IRQ,
    // Flash read port
    input wire logic RD_REQ,
    input wire logic RD_FETCH,
    input wire logic [AW-1:0] RD_ADDR,
    output logic [31:0] RD_DATA,
    output logic RD_FAULT,
    // Bit-band access
    input wire logic [31:0] BB_ADDR,
    input wire logic BB_WR,
    input wire logic BB_WDATA,
    output logic BB_HIT,
    output logic [31:0] BB_BYTE_ADDR,
    output logic [7:0] BB_BYTE_MASK,
    output logic [7:0] BB_BYTE_VALUE,
    output logic BB_WRITE_STROBE,
    input wire logic [7:0] BB_RDBYTE,
    output logic BB_RDBIT
);

    localparam int WPU = 256;
    logic [31:0] flash_mem [DEPTH];
    fpt_pkg::fpt_state_t state;
    fpt_pkg::fpt_op_t op;
    logic [AW-1:0] op_addr;
    logic [31:0] op_data;
    logic timer_start;
    logic timer_done;
    logic [7:0] timer_len;
    logic [2:0] bb_bit;
    // Nonvolatile copies, as shipped
    logic [NREG-1:0] nv_pe = NREG'(`FPT_PROT_RESET);
    logic [NREG-1:0] nv_re = NREG'(`FPT_PROT_RESET);
    logic reload_nv;
    logic [NREG-1:0] live_pe;
    logic [NREG-1:0] live_re;

    // ****************************************
    // Command decode
    // ****************************************
    wire key_ok = CTRL_WDATA[31:16] == `FPT_KEY;
    wire cmd_prog = CTRL_WR && key_ok && CTRL_WDATA[3:0] == `FPT_CMD_WRITE;
    wire cmd_erase = CTRL_WR && key_ok && CTRL_WDATA[3:0] == `FPT_CMD_ERASE;
    wire cmd_commit = CTRL_WR && key_ok && CTRL_WDATA[3:0] == `FPT_CMD_COMMIT;
    wire [AW-1:0] cmd_addr = FLASH_ADDRESS_REG[AW-1:0];
    wire [4:0] cmd_region = 5'(cmd_addr >> `FPT_REGION_LSB);
    wire [4:0] rd_region = 5'(RD_ADDR >> `FPT_REGION_LSB);
    // ****************************************
    // Protection policy
    // ****************************************
    // Committed view until the reload lands
    assign live_pe = reload_nv ? nv_pe : REGION_PROGRAM_ENABLE;
    assign live_re = reload_nv ? nv_re : REGION_READ_ENABLE;
    wire change_ok = live_pe[cmd_region];
    wire change_req = (cmd_prog || cmd_erase) && state == fpt_pkg::FPT_IDLE;
    wire change_blocked = change_req && !change_ok;
    wire rd_allowed = RD_FETCH || live_re[rd_region];
    wire rd_refused = RD_REQ && !rd_allowed;
    wire commit_re = FLASH_ADDRESS_REG == `FPT_COMMIT_RE0;
    wire commit_pe = FLASH_ADDRESS_REG == `FPT_COMMIT_PE0;
    wire [AW-3:0] word_idx = op_addr[AW-1:2];
    wire [AW-3:0] unit_base = {op_addr[AW-1:`FPT_UNIT_LSB], 8'h00};

    // ****************************************
    // Protection registers
    // ****************************************
    // Write takes effect at the next edge
    wire [NREG-1:0] next_pe = (PROT_WR && PROT_SEL_PE) ? PROT_WDATA : live_pe;
    wire [NREG-1:0] next_re = (PROT_WR && !PROT_SEL_PE) ? PROT_WDATA : live_re;

    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            REGION_PROGRAM_ENABLE <= NREG'(`FPT_PROT_RESET);
            REGION_READ_ENABLE <= NREG'(`FPT_PROT_RESET);
            reload_nv <= 1'b1;
        end
        else
        begin
            REGION_PROGRAM_ENABLE <= next_pe;
            REGION_READ_ENABLE <= next_re;
            reload_nv <= 1'b0;
        end
    end

    // Nonvolatile copy survives reset, as the flash cells do
    // Committed bits only clear
    always_ff @(posedge MCLK)
    begin
        if (state == fpt_pkg::FPT_BUSY && op == fpt_pkg::FPT_OP_COMMIT && timer_done)
        begin
            if (op_data[0])
                nv_pe <= nv_pe & REGION_PROGRAM_ENABLE;
            else
                nv_re <= nv_re & REGION_READ_ENABLE;
        end
    end
    assign COMMITTED_PE = nv_pe;
    assign COMMITTED_RE = nv_re;

    // ****************************************
    // Microsecond reload
    // ****************************************
    // Reset to 8'h31 (49), not the maximum
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
            MICROSECOND_RELOAD <= `FPT_USEC_RESET;
        else if (USEC_WR)
            MICROSECOND_RELOAD <= USEC_WDATA;
    end

    // ****************************************
    // Operation sequencer
    // ****************************************
    assign timer_len = (op == fpt_pkg::FPT_OP_ERASE) ? 8'(`FPT_ERASE_US) : 8'(`FPT_PROG_US);
    assign BUSY = state == fpt_pkg::FPT_BUSY;

    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state <= fpt_pkg::FPT_IDLE;
            op <= fpt_pkg::FPT_OP_PROG;
            op_addr <= '0;
            op_data <= '0;
            timer_start <= 1'b0;
        end
        else
        begin
            timer_start <= 1'b0;
            unique case (state)
                fpt_pkg::FPT_IDLE:
                begin
                    if (change_req && change_ok)
                    begin
                        op <= cmd_prog ? fpt_pkg::FPT_OP_PROG : fpt_pkg::FPT_OP_ERASE;
                        op_addr <= cmd_addr;
                        op_data <= FLASH_DATA;
                        timer_start <= 1'b1;
                        state <= fpt_pkg::FPT_BUSY;
                    end
                    else if (cmd_commit && (commit_re || commit_pe))
                    begin
                        op <= fpt_pkg::FPT_OP_COMMIT;
                        op_data <= {31'h0, commit_pe};
                        timer_start <= 1'b1;
                        state <= fpt_pkg::FPT_BUSY;
                    end
                end
                fpt_pkg::FPT_BUSY:
                begin
                    if (timer_done)
                        state <= fpt_pkg::FPT_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Flash array
    // ****************************************
    always_ff @(posedge MCLK)
    begin
        if (state == fpt_pkg::FPT_BUSY && timer_done)
        begin
            if (op == fpt_pkg::FPT_OP_PROG)
                flash_mem[word_idx] <= flash_mem[word_idx] & op_data;
            else if (op == fpt_pkg::FPT_OP_ERASE)
                for (int i = 0; i < WPU; i++)
                    flash_mem[unit_base + (AW-2)'(i)] <= 32'hFFFF_FFFF;
        end
    end

    // ****************************************
    // Fault status
    // ****************************************
    // Blocked change or refused read, masked interrupt
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
            ACCESS_FAULT_RAW <= 1'b0;
        else if (change_blocked || rd_refused)
            ACCESS_FAULT_RAW <= 1'b1;
        else if (FAULT_CLEAR)
            ACCESS_FAULT_RAW <= 1'b0;
    end
    assign ACCESS_FAULT_IRQ = ACCESS_FAULT_RAW && ACCESS_FAULT_MASK;

    // ****************************************
    // Read port
    // ****************************************
    // Refused read returns zeros
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            RD_DATA <= '0;
            RD_FAULT <= 1'b0;
        end
        else
        begin
            RD_FAULT <= rd_refused;
            if (RD_REQ)
                RD_DATA <= rd_allowed ? flash_mem[RD_ADDR[AW-1:2]] : 32'h0000_0000;
        end
    end

    // ****************************************
    // Bit-band
    // ****************************************
    fpt_bitband u_bitband (
        .addr(BB_ADDR),
        .hit(BB_HIT),
        .byte_addr(BB_BYTE_ADDR),
        .bit_num(bb_bit)
    );

    assign BB_BYTE_MASK = 8'h01 << bb_bit;
    assign BB_BYTE_VALUE = BB_WDATA ? BB_BYTE_MASK : 8'h00;
    assign BB_WRITE_STROBE = BB_HIT && BB_WR;
    assign BB_RDBIT = BB_RDBYTE[bb_bit];

    // ****************************************
    // Timer
    // ****************************************
    fpt_usec_timer #(
        .RW(8),
        .CW(8)
    ) u_timer (
        .mclk(MCLK),
        .resetn(RESETN),
        .reload(MICROSECOND_RELOAD),
        .start(timer_start),
        .length_us(timer_len),
        .done(timer_done)
    );

endmodule

// [tb/fpt_core_properties.sv]
// Checker for the flash protection and timing block
`timescale 1ns/100ps
module fpt_core_properties #(
    parameter int NREG = 32,
    parameter int AW = 16
)
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // Protection and timing
    input wire logic [NREG-1:0] REGION_PROGRAM_ENABLE,
    input wire logic [NREG-1:0] REGION_READ_ENABLE,
    input wire logic [7:0] MICROSECOND_RELOAD,
    input wire logic CTRL_WR,
    input wire logic [31:0] CTRL_WDATA,
    input wire logic [31:0] FLASH_ADDRESS_REG,
    input wire logic BUSY,
    // Faults
    input wire logic ACCESS_FAULT_MASK,
    input wire logic FAULT_CLEAR,
    input wire logic ACCESS_FAULT_RAW,
    input wire logic ACCESS_FAULT_IRQ,
    // Reads
    input wire logic RD_REQ,
    input wire logic RD_FETCH,
    input wire logic [AW-1:0] RD_ADDR,
    input wire logic [31:0] RD_DATA,
    input wire logic RD_FAULT,
    // Bit-band
    input wire logic [31:0] BB_ADDR,
    input wire logic BB_HIT,
    input wire logic [31:0] BB_BYTE_ADDR,
    input wire logic [7:0] BB_BYTE_MASK,
    input wire logic [7:0] BB_RDBYTE,
    input wire logic BB_RDBIT
);
    // ****
    // Properties
    // ****
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    wire chg = CTRL_WR && !BUSY && CTRL_WDATA[31:16] == 16'hA442 && CTRL_WDATA[3:0] inside {4'h1, 4'h2};
    wire pe_on = REGION_PROGRAM_ENABLE[FLASH_ADDRESS_REG[15:11]];
    AST_RESET_OPEN: assert property ($rose(RESETN) |->
        &REGION_PROGRAM_ENABLE && &REGION_READ_ENABLE && MICROSECOND_RELOAD == 8'h31) else $error("reset values");
    AST_RD_ZERO: assert property (RD_REQ && !RD_FETCH && !REGION_READ_ENABLE[RD_ADDR[15:11]]
        |=> RD_DATA == 32'h0000_0000 && RD_FAULT) else $error("forbidden read not zero");
    AST_PE_BLOCK: assert property (chg && !pe_on |=> ##[0:1] ACCESS_FAULT_RAW && !BUSY)
        else $error("blocked change");
    AST_PE_START: assert property (chg && pe_on |=> BUSY[*8]) else $error("change not started");
    AST_RAW_HOLD: assert property (ACCESS_FAULT_RAW && !FAULT_CLEAR |=> ACCESS_FAULT_RAW)
        else $error("fault flag lost");
    AST_IRQ: assert property (ACCESS_FAULT_IRQ == (ACCESS_FAULT_RAW && ACCESS_FAULT_MASK))
        else $error("irq mismatch");
    AST_BB_MAP: assert property (BB_HIT |-> BB_BYTE_ADDR == 32'h2000_0000 + ((BB_ADDR - 32'h2200_0000) >> 5)
        && BB_BYTE_MASK == 8'h01 << BB_ADDR[4:2]) else $error("alias decode");
    AST_BB_BIT: assert property (BB_HIT |-> BB_RDBIT == BB_RDBYTE[BB_ADDR[4:2]])
        else $error("alias read bit");
    C_PROG: cover property ($rose(BUSY));
    C_RDFAULT: cover property (RD_FAULT);
    C_BB: cover property (BB_HIT && BB_RDBIT);
endmodule

bind fpt_core fpt_core_properties #(.NREG(NREG), .AW(AW)) i_fpt_core_properties (.MCLK, .RESETN,
    .REGION_PROGRAM_ENABLE, .REGION_READ_ENABLE, .MICROSECOND_RELOAD, .CTRL_WR, .CTRL_WDATA,
    .FLASH_ADDRESS_REG, .BUSY, .ACCESS_FAULT_MASK, .FAULT_CLEAR, .ACCESS_FAULT_RAW, .ACCESS_FAULT_IRQ,
    .RD_REQ, .RD_FETCH, .RD_ADDR, .RD_DATA, .RD_FAULT, .BB_ADDR, .BB_HIT, .BB_BYTE_ADDR, .BB_BYTE_MASK,
    .BB_RDBYTE, .BB_RDBIT);

// [tb/fpt_sram_model.sv]
// Byte SRAM behind the bit-band port
`timescale 1ns/100ps
module fpt_sram_model (
    // Clock
    input wire logic mclk,
    // Byte access
    input wire logic hit,
    input wire logic [31:0] byte_addr,
    input wire logic [7:0] mask,
    input wire logic [7:0] value,
    input wire logic strobe,
    output logic [7:0] rdbyte
);
    logic [7:0] mem [16] = '{default: 8'h00};
    always @(posedge mclk)
        if (strobe)
            mem[byte_addr[3:0]] <= (mem[byte_addr[3:0]] & ~mask) | (value & mask);
    assign rdbyte = hit ? mem[byte_addr[3:0]] : ~mem[byte_addr[3:0]];
endmodule

// [tb/test_fpt_core.sv]
// Self-checking bench for the flash protection and timing block
`timescale 1ns/100ps
module test_fpt_core;
    logic MCLK = 0, RESETN = 0, PROT_WR = 0, PROT_SEL_PE = 0, USEC_WR = 0, CTRL_WR = 0, FAULT_CLEAR = 0;
    logic ACCESS_FAULT_MASK = 0, RD_REQ = 0, RD_FETCH = 0, BB_WR = 0, BB_WDATA = 0;
    logic [31:0] PROT_WDATA = '1, CTRL_WDATA = 0, FLASH_ADDRESS_REG = 0, FLASH_DATA = 0, BB_ADDR = 0;
    logic [7:0] USEC_WDATA = 0;
    logic [15:0] RD_ADDR = 0;
    logic [31:0] pe, re, cpe, cre, rdd, bba, fw, d2;
    logic [7:0] rl, bbm, bbv, bbr;
    logic busy, raw, irq, rdf, bbh, bbs, bbit;
    int mismatches = 0, total_checks = 0, seed = 69, n, o, b, v;
    int sb[16] = '{default: 0};
    fpt_core i_fpt_core (.MCLK, .RESETN, .PROT_WR, .PROT_SEL_PE, .PROT_WDATA, .REGION_PROGRAM_ENABLE(pe),
        .REGION_READ_ENABLE(re), .COMMITTED_PE(cpe), .COMMITTED_RE(cre), .USEC_WR, .USEC_WDATA,
        .MICROSECOND_RELOAD(rl), .CTRL_WR, .CTRL_WDATA, .FLASH_ADDRESS_REG, .FLASH_DATA, .BUSY(busy),
        .ACCESS_FAULT_MASK, .FAULT_CLEAR, .ACCESS_FAULT_RAW(raw), .ACCESS_FAULT_IRQ(irq), .RD_REQ, .RD_FETCH,
        .RD_ADDR, .RD_DATA(rdd), .RD_FAULT(rdf), .BB_ADDR, .BB_WR, .BB_WDATA, .BB_HIT(bbh), .BB_BYTE_ADDR(bba),
        .BB_BYTE_MASK(bbm), .BB_BYTE_VALUE(bbv), .BB_WRITE_STROBE(bbs), .BB_RDBYTE(bbr), .BB_RDBIT(bbit));
    fpt_sram_model i_fpt_sram_model (.mclk(MCLK), .hit(bbh), .byte_addr(bba), .mask(bbm), .value(bbv),
        .strobe(bbs), .rdbyte(bbr));
    always #50 MCLK = ~MCLK;
    // ****
    // Tasks
    // ****
    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", s, e, g);
            mismatches++;
        end
    endtask
    task automatic tick(int k = 1);
        repeat (k) @(negedge MCLK);
    endtask
    task automatic cmd(logic [3:0] op, logic [31:0] a, logic [31:0] d);
        FLASH_ADDRESS_REG = a;
        FLASH_DATA = d;
        CTRL_WDATA = {16'hA442, 12'h000, op};
        CTRL_WR = 1;
        tick();
        CTRL_WR = 0;
    endtask
    task automatic wt();
        n = 0;
        while (busy !== 1'b0 && n < 3000)
        begin
            tick();
            n++;
        end
        chk("busy", 0, busy);
    endtask
    task automatic rd(logic f, logic [15:0] a, logic [31:0] e, logic ef);
        RD_FETCH = f;
        RD_ADDR = a;
        RD_REQ = 1;
        tick();
        RD_REQ = 0;
        chk("rd_data", e, rdd);
        chk("rd_fault", ef, rdf);
        FAULT_CLEAR = 1;
        tick();
        FAULT_CLEAR = 0;
    endtask
    task automatic prot(logic s, logic [31:0] d);
        PROT_SEL_PE = s;
        PROT_WDATA = d;
        PROT_WR = 1;
        tick();
        PROT_WR = 0;
        tick();
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ****
    // Tests
    // ****
    initial
    begin
        #2000000;
        mismatches++;
        tally_and_finish();
    end
    initial
    begin
        tick(10);
        RESETN = 1;
        tick();
        chk("pe", 32'hFFFF_FFFF, pe);
        chk("re", 32'hFFFF_FFFF, re);
        chk("reload", 32'h0000_0031, rl);
        USEC_WDATA = 8'h01;
        USEC_WR = 1;
        tick();
        USEC_WR = 0;
        chk("reload", 32'h0000_0001, rl);
        $display("Test reset done");
        cmd(4'h2, 0, 0);
        wt();
        chk("erase_len", 1, n >= 195 && n <= 206);
        rd(0, 16'h03FC, 32'hFFFF_FFFF, 0);
        fw = $random(seed);
        d2 = $random(seed);
        cmd(4'h1, 0, fw);
        wt();
        chk("prog_len", 1, n >= 38 && n <= 46);
        cmd(4'h1, 0, d2);
        wt();
        fw = fw & d2;
        rd(0, 0, fw, 0);
        $display("Test program done");
        for (int k = 0; k < 4; k++)
        begin
            ACCESS_FAULT_MASK = k[0];
            prot(1, {31'h7FFF_FFFF, k[1]});
            prot(0, {31'h7FFF_FFFF, k[0]});
            cmd(k[1] ? 4'h1 : 4'h2, 0, 32'hFFFF_FFFF);
            chk("busy", {31'h0, k[1]}, busy);
            wt();
            tick();
            chk("raw", {31'h0, !k[1]}, raw);
            chk("irq", {31'h0, !k[1] && k[0]}, irq);
            rd(0, 16'h0000, k[0] ? fw : 0, !k[0]);
            rd(1, 16'h0000, fw, 0);
        end
        $display("Test protection done");
        prot(1, 32'hFFFF_FFF0);
        cmd(4'h8, 1, 0);
        wt();
        chk("cpe", 32'hFFFF_FFF0, cpe);
        prot(0, 32'hFFFF_FF0F);
        cmd(4'h8, 0, 0);
        wt();
        chk("cre", 32'hFFFF_FF0F, cre);
        prot(1, 32'h0000_0000);
        prot(0, 32'h0000_0000);
        RESETN = 0;
        tick(2);
        RESETN = 1;
        tick();
        chk("pe", 32'hFFFF_FFF0, pe);
        chk("re", 32'hFFFF_FF0F, re);
        prot(1, 32'hFFFF_FFFF);
        cmd(4'h8, 1, 0);
        wt();
        chk("cpe", 32'hFFFF_FFF0, cpe);
        $display("Test commit done");
        for (int i = 0; i < 8; i++)
        begin
            o = $random(seed) & 15;
            b = $random(seed) & 7;
            v = $random(seed) & 1;
            BB_ADDR = 32'h2200_0000 + o * 32 + b * 4;
            BB_WDATA = v[0];
            BB_WR = 1;
            #1;
            chk("bb_strobe", 1, bbs);
            chk("bb_mask", 1 << b, bbm);
            chk("bb_value", v << b, bbv);
            tick();
            BB_WR = 0;
            sb[o] = (sb[o] & ~(1 << b)) | (v << b);
            chk("bb_addr", 32'h2000_0000 + o, bba);
            chk("bb_bit", (sb[o] >> b) & 1, bbit);
            BB_ADDR = 32'h2200_0000 + o * 32 + ((b + 1) & 7) * 4;
            tick();
            chk("bb_next", (sb[o] >> ((b + 1) & 7)) & 1, bbit);
        end
        BB_ADDR = 32'h2000_0000;
        tick();
        chk("bb_hit", 0, bbh);
        $display("Test bitband done");
        tally_and_finish();
    end
endmodule
